// File: hw/io_ports_pkg.sv
// package of constants for the three bidirectional general purpose ports
// assumes a byte-wide processor load/store bus with a 12-bit address
package io_ports_pkg;
   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_DATA_A = 12'h000;
   localparam logic [11:0] ADDR_DATA_B = 12'h001;
   localparam logic [11:0] ADDR_DATA_C = 12'h002;
   localparam logic [11:0] ADDR_DIR_A = 12'h004;
   localparam logic [11:0] ADDR_DIR_B = 12'h005;
   localparam logic [11:0] ADDR_DIR_C = 12'h006;
   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int PORT_A_W = 8;
   localparam int PORT_B_W = 8;
   localparam int PORT_C_W = 4;
   localparam logic [7:0] DIR_RESET = 8'h00;
   // direction register reads as all ones; software must not rely on it
   localparam logic [7:0] DIR_READ_VALUE = 8'hff;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : io_ports_pkg

// File: hw/io_port_slice.sv
// one port: direction register, output latch, pin read multiplexer
// assumes synchronous pin inputs and a single-cycle store strobe
`timescale 1ns/1ps
module io_port_slice import io_ports_pkg::*; #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // store side
   input wire logic data_we,
   input wire logic dir_we,
   input wire logic [WIDTH-1:0] wdata,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   // read side
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] dir_ff;
   logic [WIDTH-1:0] latch_ff;
   logic [WIDTH-1:0] nxt_dir;

   assign nxt_dir = dir_we ? wdata : dir_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         dir_ff <= DIR_RESET[WIDTH-1:0]; // see R3
      end else begin
         dir_ff <= nxt_dir; // see R2
      end
   end

   // no reset on the latch: contents stay unknown until written
   always_ff @(posedge clk) begin
      if (data_we) begin
         latch_ff <= wdata; // see R4 see R12
      end
   end

   assign pin_out = latch_ff;
   assign pin_oe = dir_ff; // see R7
   // per bit: output pins return the latch, input pins the pin level
   assign rdata = (dir_ff & latch_ff) | (~dir_ff & pin_in); // see R6 see R7

endmodule : io_port_slice

// File: hw/io_ports.sv
// three bidirectional general purpose ports on the processor store bus
// assumes single-cycle loads/stores, pins synchronous to clk
//
// Summary of operation
// R1 - twenty pins over three ports, each pin input or output by software
// R2 - direction bit 1 makes the pin output, 0 makes it input
// R3 - reset clears all direction bits, so all pins come up as inputs
// R4 - reset leaves the output data latches untouched and undefined
// R5 - software should load a latch before turning its pins to output
// R6 - an output pin reads back as its latched bit, not the pin level
// R7 - an input pin has its driver off and reads the pin level
// R8 - ports b and c float as inputs, port a has pull-ups
// R9 - write-only direction registers at 004, 005 and 006 hex
// R10 - software must not trust a direction register read value
// R11 - software writes direction with whole-byte stores, not bit set/clear
// R12 - every data store writes all latch bits, even for input pins
// R13 - the interrupt pin level is readable for branch tests
// R14 - ports a and b eight bits, port c four, upper c bits ignored
`timescale 1ns/1ps
module io_ports import io_ports_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // processor bus
   input wire logic [ADDR_W-1:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // port a pins (pull-ups outside)
   input wire logic [PORT_A_W-1:0] pa_in,
   output logic [PORT_A_W-1:0] pa_out,
   output logic [PORT_A_W-1:0] pa_oe,
   output logic pa_pullup_en,
   // port b pins
   input wire logic [PORT_B_W-1:0] pb_in,
   output logic [PORT_B_W-1:0] pb_out,
   output logic [PORT_B_W-1:0] pb_oe,
   // port c pins
   input wire logic [PORT_C_W-1:0] pc_in,
   output logic [PORT_C_W-1:0] pc_out,
   output logic [PORT_C_W-1:0] pc_oe,
   // interrupt pin level for branch tests
   input wire logic int_pin_n,
   output logic int_level
);
   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   // one select per register, shared by the store strobes and the read mux
   wire sel_da = hit(addr, ADDR_DATA_A);
   wire sel_db = hit(addr, ADDR_DATA_B);
   wire sel_dc = hit(addr, ADDR_DATA_C);
   wire sel_ra = hit(addr, ADDR_DIR_A); // see R9
   wire sel_rb = hit(addr, ADDR_DIR_B); // see R9
   wire sel_rc = hit(addr, ADDR_DIR_C); // see R9
   wire is_dir = sel_ra | sel_rb | sel_rc;
   wire is_data = sel_da | sel_db | sel_dc;
   // anything else is ignored on a store and reads as a constant
   wire is_unmapped = ~(is_dir | is_data);

   // store strobes
   wire we_da = wr_en & sel_da;
   wire we_db = wr_en & sel_db;
   wire we_dc = wr_en & sel_dc;
   wire we_ra = wr_en & sel_ra;
   wire we_rb = wr_en & sel_rb;
   wire we_rc = wr_en & sel_rc;

   logic [PORT_A_W-1:0] rd_a;
   logic [PORT_B_W-1:0] rd_b;
   logic [PORT_C_W-1:0] rd_c;

   // ---------------------------------------------------------------
   // ports
   // ---------------------------------------------------------------
   // port a: eight pins, pull-ups sit outside the slice
   io_port_slice #(
      .WIDTH(PORT_A_W)
   ) u_port_a ( // see R1
      .clk(clk),
      .srst(srst),
      .data_we(we_da),
      .dir_we(we_ra),
      .wdata(wdata[PORT_A_W-1:0]),
      .pin_in(pa_in),
      .pin_out(pa_out),
      .pin_oe(pa_oe),
      .rdata(rd_a)
   );

   // port b: eight three-state pins
   io_port_slice #(
      .WIDTH(PORT_B_W)
   ) u_port_b (
      .clk(clk),
      .srst(srst),
      .data_we(we_db),
      .dir_we(we_rb),
      .wdata(wdata[PORT_B_W-1:0]),
      .pin_in(pb_in),
      .pin_out(pb_out),
      .pin_oe(pb_oe),
      .rdata(rd_b)
   );

   // upper store bits of port c are simply dropped
   io_port_slice #(
      .WIDTH(PORT_C_W)
   ) u_port_c ( // see R14
      .clk(clk),
      .srst(srst),
      .data_we(we_dc),
      .dir_we(we_rc),
      .wdata(wdata[PORT_C_W-1:0]),
      .pin_in(pc_in),
      .pin_out(pc_out),
      .pin_oe(pc_oe),
      .rdata(rd_c)
   );

   // port a pull-ups are always on; b and c float when not driven
   assign pa_pullup_en = 1'b1; // see R8

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire [7:0] rd_sel =
      sel_da ? rd_a :
      sel_db ? rd_b :
      sel_dc ? {4'h0, rd_c} :
      is_dir ? DIR_READ_VALUE : UNMAPPED_READ; // see R10
   // read data is combinational so a load sees the pin in the same cycle
   assign rdata = rd_en ? rd_sel : 8'h00;
   assign int_level = int_pin_n; // see R13

   // ---------------------------------------------------------------
   // checks: direction registers
   // ---------------------------------------------------------------
   AST_RESET_INPUTS: assert property (@(posedge clk) // see R3
      srst |=> (pa_oe == 8'h00 && pb_oe == 8'h00 && pc_oe == 4'h0))
      else $error("direction not cleared by reset");

   AST_DIR_FOLLOWS: assert property (@(posedge clk) // see R2
      disable iff (srst) we_rb |=> pb_oe == $past(wdata))
      else $error("port b direction did not take store");

   AST_DIR_A_FOLLOWS: assert property (@(posedge clk) // see R2
      disable iff (srst) we_ra |=> pa_oe == $past(wdata))
      else $error("port a direction did not take store");

   AST_DIR_C_FOLLOWS: assert property (@(posedge clk) // see R14
      disable iff (srst) we_rc |=> pc_oe == $past(wdata[PORT_C_W-1:0]))
      else $error("port c direction did not take store");

   AST_DIR_HOLDS: assert property (@(posedge clk) // see R9
      disable iff (srst) !we_ra |=> $stable(pa_oe))
      else $error("port a direction changed without store");

   AST_DIR_B_HOLDS: assert property (@(posedge clk) // see R9
      disable iff (srst) !we_rb |=> $stable(pb_oe))
      else $error("port b direction changed without store");

   AST_DIR_C_HOLDS: assert property (@(posedge clk) // see R9
      disable iff (srst) !we_rc |=> $stable(pc_oe))
      else $error("port c direction changed without store");

   // ---------------------------------------------------------------
   // checks: output latches
   // ---------------------------------------------------------------
   AST_LATCH_ALL: assert property (@(posedge clk) // see R12
      we_da |=> pa_out == $past(wdata))
      else $error("port a latch missed a store");

   AST_LATCH_B: assert property (@(posedge clk) // see R12
      we_db |=> pb_out == $past(wdata))
      else $error("port b latch missed a store");

   AST_LATCH_C: assert property (@(posedge clk) // see R14
      we_dc |=> pc_out == $past(wdata[PORT_C_W-1:0]))
      else $error("port c latch missed a store");

   // ---------------------------------------------------------------
   // checks: read path
   // ---------------------------------------------------------------
   AST_OUT_READ: assert property (@(posedge clk) // see R6
      disable iff (srst) (rd_en && sel_db && pb_oe == 8'hff)
      |-> rdata == pb_out)
      else $error("output pins did not read the latch");

   AST_IN_READ: assert property (@(posedge clk) // see R7
      disable iff (srst) (rd_en && sel_da && pa_oe == 8'h00)
      |-> rdata == pa_in)
      else $error("input pins did not read the pin level");

   AST_C_OUT_READ: assert property (@(posedge clk) // see R6
      disable iff (srst) (rd_en && sel_dc && pc_oe == 4'hf)
      |-> rdata[3:0] == pc_out)
      else $error("port c output pins did not read the latch");

   AST_C_IN_READ: assert property (@(posedge clk) // see R7
      disable iff (srst) (rd_en && sel_dc && pc_oe == 4'h0)
      |-> rdata[3:0] == pc_in)
      else $error("port c input pins did not read the pin level");

   AST_C_UPPER: assert property (@(posedge clk) // see R14
      disable iff (srst) (rd_en && sel_dc) |-> rdata[7:4] == 4'h0)
      else $error("port c upper bits not zero");

   AST_DIR_READ: assert property (@(posedge clk) // see R10
      disable iff (srst) (rd_en && is_dir) |-> rdata == DIR_READ_VALUE)
      else $error("direction read not the fixed value");

   AST_UNMAPPED_READ: assert property (@(posedge clk)
      disable iff (srst) (rd_en && is_unmapped) |-> rdata == UNMAPPED_READ)
      else $error("unmapped read not the fixed value");

   AST_IDLE_READ: assert property (@(posedge clk)
      disable iff (srst) !rd_en |-> rdata == 8'h00)
      else $error("read data not zero without a load");

   // ---------------------------------------------------------------
   // checks: pins outside the ports
   // ---------------------------------------------------------------
   AST_INT_LEVEL: assert property (@(posedge clk) // see R13
      int_level == int_pin_n)
      else $error("interrupt level not passed");

   AST_PULLUP: assert property (@(posedge clk) pa_pullup_en) // see R8
      else $error("port a pull-ups off");

endmodule : io_ports

// File: tb/pin_loads.sv
// outside loads and drivers on the port pins
// assumes outside drivers overpower the port's own drivers
`timescale 1ns/1ps
module pin_loads import io_ports_pkg::*; (
   // port side
   input wire logic clk,
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe,
   input wire logic pa_pullup_en,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe,
   input wire logic [3:0] pc_out,
   input wire logic [3:0] pc_oe,
   // outside drivers
   input wire logic ext_en,
   input wire logic [19:0] ext_val,
   // pin levels
   output logic [7:0] pa_in,
   output logic [7:0] pb_in,
   output logic [3:0] pc_in
);
   logic [7:0] flt_ff = 8'h5a;
   // a floating line must never look stable
   always @(posedge clk) begin
      flt_ff <= ~flt_ff;
   end
   wire [7:0] a_idle = pa_pullup_en ? 8'hff : flt_ff;
   assign pa_in = ext_en ? ext_val[7:0] : (pa_oe & pa_out) | (~pa_oe & a_idle);
   assign pb_in = ext_en ? ext_val[15:8] :
                  (pb_oe & pb_out) | (~pb_oe & flt_ff);
   assign pc_in = ext_en ? ext_val[19:16] :
                  (pc_oe & pc_out) | (~pc_oe & flt_ff[3:0]);
endmodule : pin_loads

// File: tb/tb_io_ports.sv
// self-checking bench for the three general purpose ports
// assumes pin_loads as the outside world
`timescale 1ns/1ps
module tb_io_ports import io_ports_pkg::*;;
   logic clk = 0, srst = 1, wr_en = 0, rd_en = 0, ext_en = 1, int_pin_n = 1;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00, rdata, pa_out, pa_oe, pb_out, pb_oe;
   logic [7:0] pa_in, pb_in;
   logic [3:0] pc_out, pc_oe, pc_in;
   logic [19:0] ext_val = 20'h95ac3;
   logic pa_pullup_en, int_level;
   int miscompares = 0, check_count = 0, cycles = 0;
   io_ports u_dut (.clk, .srst, .addr, .wr_en, .rd_en, .wdata, .rdata, .pa_in,
      .pa_out, .pa_oe, .pa_pullup_en, .pb_in, .pb_out, .pb_oe, .pc_in,
      .pc_out, .pc_oe, .int_pin_n, .int_level);
   pin_loads u_loads (.clk, .pa_out, .pa_oe, .pa_pullup_en, .pb_out, .pb_oe,
      .pc_out, .pc_oe, .ext_en, .ext_val, .pa_in, .pb_in, .pc_in);
   initial begin
      forever #50 clk = ~clk;
   end
   // -----------------------------
   // bus and compare tasks
   // -----------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1 wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 addr = a;
      rd_en = 1'b1;
      #10 chk(rdata, exp);
      @(posedge clk);
      #1 rd_en = 1'b0;
   endtask : rd
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         end_of_test();
      end
   end
   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic reset_state();
      chk(pa_oe | pb_oe | {4'h0, pc_oe}, DIR_RESET);
   endtask : reset_state
   task automatic input_read();
      rd(ADDR_DATA_A, 8'hc3);
      rd(ADDR_DATA_C, 8'h09);
   endtask : input_read
   task automatic output_a();
      // latch first, then one whole-byte direction store
      wr(ADDR_DATA_A, 8'ha5);
      wr(ADDR_DIR_A, 8'h0f);
      chk(pa_oe, 8'h0f);
      ext_val = 20'h95a30;
      rd(ADDR_DATA_A, 8'h35);
      // a direction register reads the fixed value, not what was stored
      rd(ADDR_DIR_A, DIR_READ_VALUE);
   endtask : output_a
   task automatic latch_b();
      wr(ADDR_DATA_B, 8'h3c);
      chk(pb_oe, 8'h00);
      chk(pb_out, 8'h3c);
      wr(ADDR_DIR_B, 8'hff);
      rd(ADDR_DATA_B, 8'h3c);
   endtask : latch_b
   task automatic port_c();
      wr(ADDR_DATA_C, 8'hff);
      wr(ADDR_DIR_C, 8'hff);
      chk({pc_oe, pc_out}, 8'hff);
      rd(ADDR_DATA_C, 8'h0f);
   endtask : port_c
   task automatic unmapped();
      wr(12'h003, 8'hff);
      rd(12'h003, UNMAPPED_READ);
      chk(pa_oe, 8'h0f);
      chk(pb_out, 8'h3c);
   endtask : unmapped
   task automatic mid_reset();
      @(posedge clk);
      #1 srst = 1'b1;
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      chk(pa_oe | pb_oe | {4'h0, pc_oe}, DIR_RESET);
      // the latches keep what software stored before the reset
      chk(pa_out, 8'ha5);
      chk(pb_out, 8'h3c);
      chk({4'h0, pc_out}, 8'h0f);
   endtask : mid_reset
   task automatic pull_up();
      // direction is judged at the pins, never from a read of it
      wr(ADDR_DIR_A, 8'h00);
      ext_en = 1'b0;
      rd(ADDR_DATA_A, 8'hff);
      chk({7'h00, pa_pullup_en}, 8'h01);
   endtask : pull_up
   task automatic int_pin();
      @(posedge clk);
      #1 int_pin_n = 1'b0;
      #10 chk({7'h00, int_level}, 8'h00);
      @(posedge clk);
      #1 int_pin_n = 1'b1;
      #10 chk({7'h00, int_level}, 8'h01);
   endtask : int_pin
   initial begin
      repeat (10) @(posedge clk);
      #1 srst = 1'b0;
      reset_state();
      input_read();
      output_a();
      latch_b();
      port_c();
      unmapped();
      mid_reset();
      pull_up();
      int_pin();
      end_of_test();
   end
endmodule : tb_io_ports
